// ---- hdl/sadc_device.sv ----
`timescale 1ns/1ps
`default_nettype none
module sadc_device
  import sadc_pkg::*;
(
  // core clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // serial link, clocked by the host's serial clock
  sadc_link_if.device link,
  // sampled input code
  input wire logic [RES_BITS-1:0] analog_input_pin,
  // status
  output logic converting,
  output logic tracking,
  output logic shut_down,
  output logic internal_ref_on
);

  typedef enum logic [1:0] {
    DS_TRACK = 2'b00,
    DS_CONVERT = 2'b01,
    DS_READY = 2'b10
  } sadc_dev_state_type;

  typedef struct packed {
    sadc_dev_state_type state;
    logic cs_meta;
    logic cs_sync;
    logic cs_prev;
    logic [1:0] pd_meta;
    logic [1:0] pd_sync;
    logic [CNT_W-1:0] cnt_meta;
    logic [CNT_W-1:0] cnt_sync;
    logic [RES_BITS-1:0] held;
    logic [RES_BITS-1:0] approx;
    logic [CNT_W-1:0] bit_idx;
    logic [STEP_W-1:0] timer;
    logic dout_drv;
    logic dout_oe_n;
    logic converting;
    logic tracking;
    logic shut_down;
    logic internal_ref_on;
  } sadc_dev_core_type;

  typedef struct packed {
    logic [CNT_W-1:0] gray;
  } sadc_dev_link_type;

  localparam sadc_dev_core_type CORE_RESET = '{
    state: DS_TRACK,
    cs_meta: 1'b1,
    cs_sync: 1'b1,
    cs_prev: 1'b1,
    pd_meta: 2'h0,
    pd_sync: 2'h0,
    cnt_meta: 4'h0,
    cnt_sync: 4'h0,
    held: 12'h000,
    approx: 12'h000,
    bit_idx: 4'h0,
    timer: '0,
    dout_drv: 1'b0,
    dout_oe_n: 1'b1,
    converting: 1'b0,
    tracking: 1'b1,
    shut_down: 1'b0,
    internal_ref_on: 1'b0
  };

  sadc_dev_core_type core;
  sadc_dev_core_type next_core;
  sadc_dev_link_type lnk;
  sadc_dev_link_type next_lnk;

  // link side: counts falling edges of the frame. chip select high clears it
  // asynchronously, so nothing in this domain needs an edge outside a frame.
  logic link_clr;
  assign link_clr = link.cs_n | ~arst_n;

  always_comb begin
    logic [CNT_W-1:0] bin;
    bin = sadc_gray2bin(lnk.gray);
    next_lnk = lnk;
    // saturate so surplus edges keep selecting zeros
    if (bin < FRAME_EDGES) begin
      next_lnk.gray = sadc_bin2gray(bin + 4'h1);
    end
  end

  // the shift happens on the falling edge only; the core follows the count
  always_ff @(negedge link.sclk or posedge link_clr) begin
    if (link_clr) begin
      lnk <= '{gray: 4'h0};
    end else begin
      lnk <= next_lnk;
    end
  end

  // core side
  always_comb begin
    logic [CNT_W-1:0] edges;
    logic [CNT_W-1:0] sel;
    logic [RES_BITS-1:0] trial;
    logic cs_fall;
    edges = '0;
    sel = '0;
    trial = '0;
    cs_fall = 1'b0;
    next_core = core;

    // two stages before any logic looks at a link pin or the link count
    next_core.cs_meta = link.cs_n;
    next_core.cs_sync = core.cs_meta;
    next_core.cs_prev = core.cs_sync;
    next_core.pd_meta = {link.pd_oe_n, link.pd_drv};
    next_core.pd_sync = core.pd_meta;
    next_core.cnt_meta = lnk.gray;
    next_core.cnt_sync = core.cnt_meta;

    // pd_sync[1] high means the pin floats
    next_core.shut_down = ~core.pd_sync[1] & ~core.pd_sync[0];
    next_core.internal_ref_on = ~core.pd_sync[1] & core.pd_sync[0];

    cs_fall = core.cs_prev & ~core.cs_sync;
    edges = sadc_gray2bin(core.cnt_sync);

    if (core.cs_sync) begin
      // deselect ends or aborts any frame and releases the output
      next_core.state = DS_TRACK;
      next_core.dout_oe_n = 1'b1;
      next_core.dout_drv = 1'b0;
      next_core.converting = 1'b0;
      next_core.tracking = 1'b1;
    end else if (cs_fall) begin
      next_core.dout_oe_n = 1'b0;
      next_core.dout_drv = 1'b0;
      // in shutdown the output stays low: no conversion is started
      if (!core.shut_down) begin
        next_core.state = DS_CONVERT;
        next_core.held = analog_input_pin;
        next_core.approx = '0;
        next_core.bit_idx = 4'(RES_BITS - 1);
        next_core.timer = '0;
        next_core.converting = 1'b1;
        next_core.tracking = 1'b0;
      end
    end else begin
      unique case (core.state)
        DS_TRACK: begin
          next_core.state = DS_TRACK;
        end
        DS_CONVERT: begin
          // one decision per step, no serial clock needed
          if (core.timer == STEP_W'(STEP_CYCLES - 1)) begin
            next_core.timer = '0;
            trial = core.approx | (12'h001 << core.bit_idx);
            // straight binary: keep the trial bit when it does not overshoot
            if (trial <= core.held) begin
              next_core.approx = trial;
            end
            if (core.bit_idx == 4'h0) begin
              next_core.state = DS_READY;
              next_core.dout_drv = 1'b1;
              next_core.converting = 1'b0;
              next_core.tracking = 1'b1;
            end else begin
              next_core.bit_idx = core.bit_idx - 4'h1;
            end
          end else begin
            next_core.timer = core.timer + STEP_W'(1);
          end
        end
        DS_READY: begin
          // result stays in approx until deselect, read at any pace
          if (edges == 4'h0) begin
            next_core.dout_drv = 1'b1;
          end else if (edges <= RES_TOP) begin
            sel = RES_TOP - edges;
            next_core.dout_drv = core.approx[sel];
          end else begin
            next_core.dout_drv = 1'b0;
          end
        end
        default: begin
          next_core.state = DS_TRACK;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      core <= CORE_RESET;
    end else begin
      core <= next_core;
    end
  end

  assign link.dout_drv = core.dout_drv;
  assign link.dout_oe_n = core.dout_oe_n;
  assign converting = core.converting;
  assign tracking = core.tracking;
  assign shut_down = core.shut_down;
  assign internal_ref_on = core.internal_ref_on;

endmodule
`default_nettype wire

// ---- hdl/sadc_pkg.sv ----
package sadc_pkg;

  // converter word and frame
  localparam int RES_BITS = 12;
  localparam int CNT_W = 4;
  localparam logic [3:0] FRAME_EDGES = 4'hD;
  localparam logic [3:0] RES_TOP = 4'hC;

  // clock of both ends' core logic
  localparam int SYS_CLK_PERIOD_NS = 4;

  // conversion, acquisition included; longest time rounds down
  localparam int CONV_TIME_NS = 9000;
  localparam int CONV_CYCLES = CONV_TIME_NS / SYS_CLK_PERIOD_NS;
  localparam int STEP_CYCLES = CONV_CYCLES / (RES_BITS + 1);
  localparam int STEP_W = $clog2(STEP_CYCLES);

  // serial clock limits; least times round up
  localparam int SCLK_PHASE_NS = 200;
  localparam int SCLK_MAX_KHZ = 2100;
  localparam int SCLK_MIN_PERIOD_NS = (1000000 + SCLK_MAX_KHZ - 1) / SCLK_MAX_KHZ;
  localparam int PHASE_CYCLES_A = (SCLK_PHASE_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int PHASE_CYCLES_B =
    (SCLK_MIN_PERIOD_NS + 2 * SYS_CLK_PERIOD_NS - 1) / (2 * SYS_CLK_PERIOD_NS);
  localparam int SCLK_HALF_CYCLES =
    (PHASE_CYCLES_A > PHASE_CYCLES_B) ? PHASE_CYCLES_A : PHASE_CYCLES_B;

  // chip select timing
  localparam int CS_HIGH_NS = 240;
  localparam int CS_HIGH_CYCLES = (CS_HIGH_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int OUT_ENABLE_NS = 240;
  localparam int OUT_ENABLE_CYCLES =
    (OUT_ENABLE_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int ACQ_TIME_NS = 1500;
  localparam int ACQ_CYCLES = (ACQ_TIME_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int GAP_CYCLES = (ACQ_CYCLES > CS_HIGH_CYCLES) ? ACQ_CYCLES : CS_HIGH_CYCLES;

  // power sequencing
  localparam int WAKE_TIME_NS = 4000;
  localparam int WAKE_CYCLES = (WAKE_TIME_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int RESET_TIME_NS = 10000;
  localparam int RESET_CYCLES = (RESET_TIME_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int POWERUP_TIME_MS = 20;
  localparam int POWERUP_CYCLES_DFLT = POWERUP_TIME_MS * (1000000 / SYS_CLK_PERIOD_NS);
  localparam int HOST_WAIT_W = 24;

  typedef enum logic [1:0] {
    PD_SHUTDOWN = 2'b00,
    PD_INT_REF = 2'b01,
    PD_EXT_REF = 2'b10
  } sadc_pd_mode_type;

  function automatic logic [3:0] sadc_bin2gray(input logic [3:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [3:0] sadc_gray2bin(input logic [3:0] g);
    logic [3:0] b;
    b[3] = g[3];
    for (int i = 2; i >= 0; i--) begin
      b[i] = b[i + 1] ^ g[i];
    end
    return b;
  endfunction

endpackage

// ---- hdl/sadc_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface sadc_link_if;
  logic cs_n;
  logic sclk;
  logic dout_drv;
  logic dout_oe_n;
  logic pd_drv;
  logic pd_oe_n;
  wire dout_line;

  // no pull on this line: a released output shows the opposite level,
  // so a host that reads a floating line gets a wrong bit, not a lucky one
  assign dout_line = dout_oe_n ? ~dout_drv : dout_drv;

  modport device (
    input cs_n,
    input sclk,
    input pd_drv,
    input pd_oe_n,
    output dout_drv,
    output dout_oe_n
  );

  modport host (
    output cs_n,
    output sclk,
    output pd_drv,
    output pd_oe_n,
    input dout_line
  );
endinterface
`default_nettype wire

// ---- hdl/sadc_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module sadc_host
  import sadc_pkg::*;
#(
  parameter int POWERUP_CYCLES = POWERUP_CYCLES_DFLT
)(
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // serial link, this end makes the serial clock
  sadc_link_if.host link,
  // requests
  input wire logic start,
  input wire logic abort,
  input wire logic [1:0] pd_mode,
  // answers
  output logic ready,
  output logic busy,
  output logic [RES_BITS-1:0] result,
  output logic result_valid
);

  typedef enum logic [2:0] {
    HS_POWERUP = 3'b000,
    HS_IDLE = 3'b001,
    HS_WAIT_EOC = 3'b010,
    HS_HIGH = 3'b011,
    HS_LOW = 3'b100,
    HS_GAP = 3'b101
  } sadc_host_state_type;

  typedef struct packed {
    sadc_host_state_type state;
    logic dout_meta;
    logic dout_sync;
    logic [HOST_WAIT_W-1:0] wait_cnt;
    logic [CNT_W-1:0] rises;
    logic [RES_BITS:0] shift;
    logic [1:0] mode;
    logic cs_n;
    logic sclk;
    logic pd_drv;
    logic pd_oe_n;
    logic ready;
    logic busy;
    logic [RES_BITS-1:0] result;
    logic result_valid;
  } sadc_host_core_type;

  localparam sadc_host_core_type HOST_RESET = '{
    state: HS_POWERUP,
    dout_meta: 1'b0,
    dout_sync: 1'b0,
    wait_cnt: '0,
    rises: 4'h0,
    shift: 13'h0000,
    mode: PD_INT_REF,
    cs_n: 1'b1,
    sclk: 1'b0,
    pd_drv: 1'b1,
    pd_oe_n: 1'b0,
    ready: 1'b0,
    busy: 1'b0,
    result: 12'h000,
    result_valid: 1'b0
  };

  localparam logic [HOST_WAIT_W-1:0] HALF_LOAD = HOST_WAIT_W'(SCLK_HALF_CYCLES - 1);

  sadc_host_core_type st;
  sadc_host_core_type next_st;

  // wait that follows a change to a running power mode
  function automatic logic [HOST_WAIT_W-1:0] settle(input logic [1:0] m, input logic woke);
    if (m == PD_INT_REF) begin
      return HOST_WAIT_W'(POWERUP_CYCLES);
    end
    return woke ? HOST_WAIT_W'(WAKE_CYCLES) : HOST_WAIT_W'(RESET_CYCLES);
  endfunction

  always_comb begin
    next_st = st;
    next_st.dout_meta = link.dout_line;
    next_st.dout_sync = st.dout_meta;
    next_st.result_valid = 1'b0;
    if (st.wait_cnt != '0) begin
      next_st.wait_cnt = st.wait_cnt - HOST_WAIT_W'(1);
    end

    unique case (st.state)
      HS_POWERUP: begin
        if (st.wait_cnt == '0) begin
          next_st.state = HS_IDLE;
          next_st.ready = (st.mode != PD_SHUTDOWN);
        end
      end
      HS_IDLE: begin
        if (pd_mode != st.mode && pd_mode != 2'b11) begin
          // three-level pin: low, high, or released to float
          next_st.mode = pd_mode;
          next_st.pd_drv = (pd_mode == PD_INT_REF);
          next_st.pd_oe_n = (pd_mode == PD_EXT_REF);
          next_st.ready = 1'b0;
          next_st.state = HS_POWERUP;
          next_st.wait_cnt = (pd_mode == PD_SHUTDOWN) ? '0 :
            settle(pd_mode, st.mode == PD_SHUTDOWN);
        end else if (start && st.ready) begin
          next_st.state = HS_WAIT_EOC;
          next_st.cs_n = 1'b0;
          next_st.ready = 1'b0;
          next_st.busy = 1'b1;
          next_st.rises = 4'h0;
          next_st.wait_cnt = HOST_WAIT_W'(OUT_ENABLE_CYCLES);
        end
      end
      HS_WAIT_EOC: begin
        // clock stays low until the end flag shows
        if (st.wait_cnt == '0 && st.dout_sync) begin
          next_st.state = HS_HIGH;
          next_st.sclk = 1'b1;
          next_st.shift = {st.shift[RES_BITS-1:0], st.dout_sync};
          next_st.rises = 4'h1;
          next_st.wait_cnt = HALF_LOAD;
        end
      end
      HS_HIGH: begin
        if (st.wait_cnt == '0) begin
          next_st.sclk = 1'b0;
          next_st.wait_cnt = HALF_LOAD;
          if (st.rises == FRAME_EDGES) begin
            // deselect on the last falling edge, right after the LSB
            next_st.state = HS_GAP;
            next_st.cs_n = 1'b1;
            next_st.result = st.shift[RES_BITS-1:0];
            next_st.result_valid = 1'b1;
            next_st.wait_cnt = HOST_WAIT_W'(GAP_CYCLES);
          end else begin
            next_st.state = HS_LOW;
          end
        end
      end
      HS_LOW: begin
        if (st.wait_cnt == '0) begin
          next_st.state = HS_HIGH;
          next_st.sclk = 1'b1;
          next_st.shift = {st.shift[RES_BITS-1:0], st.dout_sync};
          next_st.rises = st.rises + 4'h1;
          next_st.wait_cnt = HALF_LOAD;
        end
      end
      HS_GAP: begin
        if (st.wait_cnt == '0) begin
          next_st.state = HS_IDLE;
          next_st.busy = 1'b0;
          next_st.ready = 1'b1;
        end
      end
      default: begin
        next_st.state = HS_IDLE;
      end
    endcase

    if (abort && st.busy && st.state != HS_GAP) begin
      next_st.state = HS_GAP;
      next_st.cs_n = 1'b1;
      next_st.sclk = 1'b0;
      next_st.wait_cnt = HOST_WAIT_W'(GAP_CYCLES);
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= HOST_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign link.cs_n = st.cs_n;
  assign link.sclk = st.sclk;
  assign link.pd_drv = st.pd_drv;
  assign link.pd_oe_n = st.pd_oe_n;
  assign ready = st.ready;
  assign busy = st.busy;
  assign result = st.result;
  assign result_valid = st.result_valid;

endmodule
`default_nettype wire

// ---- tb/sadc_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module sadc_props
  import sadc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // link lines
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic dout_drv,
  input wire logic dout_oe_n
);
  logic eoc_seen;
  logic sclk_q;
  logic [11:0] conv_cnt;
  logic [3:0] fall_cnt;
  logic [9:0] hi_cnt;
  logic [9:0] ph_cnt;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  // hi_cnt and ph_cnt saturate so a long idle spell never wraps into a false short gap
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      eoc_seen <= 1'b0;
      sclk_q <= 1'b0;
      conv_cnt <= 12'h000;
      fall_cnt <= 4'h0;
      hi_cnt <= 10'h3FF;
      ph_cnt <= 10'h3FF;
    end else begin
      eoc_seen <= !cs_n && (eoc_seen || (!dout_oe_n && dout_drv));
      sclk_q <= sclk;
      conv_cnt <= (cs_n || eoc_seen) ? 12'h000 : conv_cnt + 12'h001;
      fall_cnt <= cs_n ? 4'h0 : fall_cnt + {3'h0, sclk_q && !sclk};
      hi_cnt <= !cs_n ? 10'h000 : hi_cnt + {9'h000, hi_cnt != 10'h3FF};
      ph_cnt <= (sclk != sclk_q) ? 10'h000 : ph_cnt + {9'h000, ph_cnt != 10'h3FF};
    end
  end

  AST_BUSY_LOW: assert property (
    $fell(cs_n) |-> ##[1:5] (!dout_oe_n && !dout_drv)) else $error("no busy level after select");
  AST_RELEASE: assert property (
    cs_n [*6] |-> dout_oe_n) else $error("output driven while deselected");
  AST_CONV_TIME: assert property (
    (!cs_n && !eoc_seen) |-> conv_cnt <= CONV_CYCLES) else $error("end flag late");
  AST_SCLK_QUIET: assert property (
    (!cs_n && !eoc_seen) |-> !sclk) else $error("serial clock moved during conversion");
  AST_HOLD_HIGH: assert property (
    (!cs_n && eoc_seen && sclk) |-> ($stable(dout_drv) && !dout_oe_n))
    else $error("data changed while serial clock high");
  AST_FRAME_EDGES: assert property (
    ($rose(cs_n) && eoc_seen) |-> (fall_cnt + {3'h0, sclk_q && !sclk}) == FRAME_EDGES)
    else $error("wrong count of falling edges in frame");
  AST_GAP: assert property (
    $fell(cs_n) |-> int'(hi_cnt) + 1 >= GAP_CYCLES) else $error("select gap too short");
  AST_PHASE: assert property (
    (sclk != sclk_q) |-> int'(ph_cnt) + 1 >= PHASE_CYCLES_A)
    else $error("serial clock phase too short");
endmodule
`default_nettype wire

// ---- tb/tb_serial_sar_adc_readout.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module tb_serial_sar_adc_readout;
  import sadc_pkg::*;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic start = 1'b0;
  logic abort = 1'b0;
  logic [1:0] pd_mode = 2'b01;
  logic [RES_BITS-1:0] code = 12'h000;
  logic converting, tracking, shut_down, internal_ref_on;
  logic ready, busy, result_valid;
  logic [RES_BITS-1:0] result;
  int compares = 0;
  int mismatches = 0;

  always #(SYS_CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;

  sadc_link_if link_if();
  sadc_device sadc_device_inst (.sys_clk(sys_clk), .arst_n(arst_n), .link(link_if),
    .analog_input_pin(code), .converting(converting), .tracking(tracking),
    .shut_down(shut_down), .internal_ref_on(internal_ref_on));
  sadc_host #(.POWERUP_CYCLES(200)) sadc_host_inst (.sys_clk(sys_clk), .arst_n(arst_n),
    .link(link_if), .start(start), .abort(abort), .pd_mode(pd_mode), .ready(ready),
    .busy(busy), .result(result), .result_valid(result_valid));
  sadc_props sadc_props_inst (.sys_clk(sys_clk), .arst_n(arst_n), .cs_n(link_if.cs_n),
    .sclk(link_if.sclk), .dout_drv(link_if.dout_drv), .dout_oe_n(link_if.dout_oe_n));

  task automatic tick(input int n = 1);
    repeat (n) begin
      @(posedge sys_clk);
      #1;
    end
  endtask

  task automatic wait_ready();
    int i;
    i = 0;
    while (ready !== 1'b1 && i < 8000) begin
      tick();
      i++;
    end
    `CHK("ready", 1'b1, ready)
    `CHK("busy after gap", 1'b0, busy)
  endtask

  // input is moved mid-conversion so only a held sample can give the right code
  task automatic run_frame(input logic [RES_BITS-1:0] val);
    int i;
    wait_ready();
    code = val;
    start = 1'b1;
    tick();
    start = 1'b0;
    tick(20);
    `CHK("busy line", 1'b0, link_if.dout_line)
    `CHK("busy", 1'b1, busy)
    `CHK("converting", 1'b1, converting)
    code = ~val;
    i = 0;
    while (result_valid !== 1'b1 && i < 6000) begin
      tick();
      i++;
    end
    `CHK("result valid", 1'b1, result_valid)
    `CHK("result", val, result)
    tick(10);
    `CHK("tracking", 1'b1, tracking)
    `CHK("busy in gap", 1'b1, busy)
    `CHK("released line", 1'b1, link_if.dout_oe_n)
  endtask

  task automatic run_abort();
    wait_ready();
    start = 1'b1;
    tick();
    start = 1'b0;
    tick(300);
    abort = 1'b1;
    tick();
    abort = 1'b0;
    tick(10);
    `CHK("line after abort", 1'b1, link_if.dout_oe_n)
    `CHK("tracking after abort", 1'b1, tracking)
    run_frame(12'h5A3);
  endtask

  task automatic run_power();
    wait_ready();
    // the unused code must leave pin and readiness alone
    pd_mode = 2'b11;
    tick(10);
    `CHK("pin on ignored mode", 1'b0, link_if.pd_oe_n)
    `CHK("ready on ignored mode", 1'b1, ready)
    pd_mode = 2'b00;
    tick(50);
    `CHK("shut down", 1'b1, shut_down)
    `CHK("ready in shutdown", 1'b0, ready)
    start = 1'b1;
    tick(20);
    start = 1'b0;
    `CHK("line in shutdown", 1'b1, link_if.dout_oe_n)
    pd_mode = 2'b10;
    tick(10);
    `CHK("pin floats", 1'b1, link_if.pd_oe_n)
    `CHK("reference off", 1'b0, internal_ref_on)
    `CHK("running", 1'b0, shut_down)
    tick(900);
    `CHK("ready before wake", 1'b0, ready)
    run_frame(12'h3C7);
    // a mode change is only taken once the host is idle again
    wait_ready();
    pd_mode = 2'b01;
    tick(10);
    `CHK("reference on", 1'b1, internal_ref_on)
    `CHK("ready before power up", 1'b0, ready)
    run_frame(12'hC38);
  endtask

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // eight frames of about 4000 cycles plus power waits stay well under this span
  initial begin
    #400000;
    mismatches++;
    give_verdict();
  end

  initial begin
    logic [RES_BITS-1:0] codes [5];
    codes = '{12'h000, 12'hFFF, 12'h800, 12'h7FF, 12'hA5C};
    repeat (10) @(posedge sys_clk);
    #1;
    arst_n = 1'b1;
    tick(2);
    `CHK("idle line", 1'b1, link_if.dout_oe_n)
    `CHK("pin high", 1'b1, link_if.pd_drv)
    foreach (codes[k]) begin
      run_frame(codes[k]);
    end
    run_abort();
    run_power();
    give_verdict();
  end
endmodule
`default_nettype wire
